// >>> design/configurable_io_port_block.sv
// Four configurable I/O ports with readback path and input capture
//
// Behaviour
// RQ1 - Ports A,B,C eight pins, D three
// RQ2 - Output mux: data, address, cell, chip-select
// RQ3 - Readback returns exactly one selected source
// RQ4 - Driver enable is direction OR enable term
// RQ5 - Without enable term, direction alone drives
// RQ6 - Input cells latch, register or pass
// RQ7 - Fixed modes are configuration inputs only
// RQ8 - Control bit zero selects microcontroller I/O
// RQ9 - Output from data register, input readable
// RQ10 - Ports C and D have no control
// RQ11 - Logic output tri-stated by term or direction
// RQ12 - Software avoids output direction on inputs
// RQ13 - Address out: nibbles a3-a0 and a7-a4
// RQ14 - Peripheral mode bit turns Port A buffer
// RQ15 - Buffer tri-stated while select inactive
// RQ16 - Select should include program store strobe
// RQ17 - Port C cells only PC2,3,4,7
// RQ18 - Mode matrix limits per port
// RQ19 - Direction one is output, reset input
// RQ20 - Configuration registers reset to zero
// RQ21 - Writes on strobe, reads without side effects
`default_nettype none
module configurable_io_port_block
	import io_port_pkg::*;
#(
	parameter int unsigned W = PORT_W,
	parameter int unsigned DW = PORT_D_W // RQ1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Microcontroller side
	input wire logic wr_strobe_in,
	input wire logic [1:0] wr_port_in,
	input wire logic [1:0] wr_target_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [1:0] rd_port_in,
	input wire logic [2:0] rd_source_in,
	input wire logic [7:0] addr_low_in,
	input wire logic addr_strobe_in,
	input wire logic periph_mode_bit_in,
	input wire logic [7:0] mcu_data_in,
	input wire logic mcu_data_write_in,
	input wire logic periph_select_zero_in,
	input wire logic periph_select_one_in,
	// Logic array side
	input wire logic [W-1:0] macrocell_group_first_in,
	input wire logic [W-1:0] macrocell_group_second_in,
	input wire logic [1:0] external_chip_selects_in,
	input wire logic [3*W+DW-1:0] oe_term_in,
	input wire logic [3*W+DW-1:0] oe_term_defined_in,
	input wire logic [3*W+DW-1:0] logic_output_in,
	input wire logic [1:0] cell_term_a_in,
	input wire logic [1:0] cell_term_b_in,
	input wire logic [1:0] cell_term_c_in,
	// Fixed configuration
	input wire logic [W-1:0] cfg_a_from_second_in,
	input wire logic [W-1:0] cfg_cell_use_term_in,
	input wire logic [W*2-1:0] cfg_cell_mode_in,
	// Pins
	input wire logic [W-1:0] port_a_pin_in,
	input wire logic [W-1:0] port_b_pin_in,
	input wire logic [W-1:0] port_c_pin_in,
	input wire logic [DW-1:0] port_d_pin_in,
	output logic [W-1:0] port_a_pin_out,
	output logic [W-1:0] port_a_oe_out,
	output logic [W-1:0] port_b_pin_out,
	output logic [W-1:0] port_b_oe_out,
	output logic [W-1:0] port_c_pin_out,
	output logic [W-1:0] port_c_oe_out,
	output logic [DW-1:0] port_d_pin_out,
	output logic [DW-1:0] port_d_oe_out,
	output logic [7:0] port_readback_buffer_out,
	output logic [W-1:0] open_drain_a_out,
	output logic [W-1:0] open_drain_b_out
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [W-1:0] dout_a, dout_b, dout_c;
		logic [DW-1:0] dout_d;
		logic [W-1:0] dir_a, dir_b, dir_c;
		logic [DW-1:0] dir_d;
		logic [W-1:0] ctrl_a, ctrl_b;
		logic [W-1:0] drive_a, drive_b, drive_c;
		logic [DW-1:0] drive_d;
		logic [W-1:0] pa_q, pa_oe, pb_q, pb_oe, pc_q, pc_oe;
		logic [DW-1:0] pd_q, pd_oe;
		logic [7:0] rb;
	} port_state_s;

	port_state_s st_r;
	port_state_s st_nxt;
	logic [W-1:0] cap_a, cap_b, cap_c;
	logic [W-1:0] pa_val, pa_en, pb_val, pb_en, pc_val, pc_en;
	logic [DW-1:0] pd_val, pd_en;
	logic periph_on;
	logic [7:0] cells_b;
	// Zero-extend a narrow field into a byte
	function automatic logic [7:0] widen(input logic [DW-1:0] v);
		widen = {{(8 - DW){1'b0}}, v};
	endfunction

	// Driver enable of one pin
	function automatic logic pin_enable(input logic dir, input logic term,
			input logic defined);
		pin_enable = dir | (defined & term); // RQ4 RQ5 RQ19
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Input cells exist on Ports A, B and C only
	input_capture_cell #(.WIDTH(W)) u_cap_a (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(port_a_pin_in),
		.cell_mode_in(cfg_cell_mode_in), .use_term_in(cfg_cell_use_term_in),
		.addr_strobe_in(addr_strobe_in), .term_low_in(cell_term_a_in[0]),
		.term_high_in(cell_term_a_in[1]), .cell_out(cap_a)); // RQ6
	input_capture_cell #(.WIDTH(W)) u_cap_b (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(port_b_pin_in),
		.cell_mode_in(cfg_cell_mode_in), .use_term_in(cfg_cell_use_term_in),
		.addr_strobe_in(addr_strobe_in), .term_low_in(cell_term_b_in[0]),
		.term_high_in(cell_term_b_in[1]), .cell_out(cap_b)); // RQ6
	input_capture_cell #(.WIDTH(W)) u_cap_c (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .pin_in(port_c_pin_in),
		.cell_mode_in(cfg_cell_mode_in), .use_term_in(cfg_cell_use_term_in),
		.addr_strobe_in(addr_strobe_in), .term_low_in(cell_term_c_in[0]),
		.term_high_in(cell_term_c_in[1]), .cell_out(cap_c)); // RQ6

	////////////////////////////////////////////////////////////////////////
	// Pin drive
	always_comb begin
		// Select inactive low keeps the data buffer off
		periph_on = periph_mode_bit_in &
			(periph_select_zero_in | periph_select_one_in); // RQ14 RQ15
		cells_b = macrocell_group_second_in;
		for (int i = 0; i < W; i++) begin
			// Port A: peripheral buffer, cell, address or data
			pa_en[i] = pin_enable(st_r.dir_a[i], oe_term_in[i],
				oe_term_defined_in[i]);
			if (periph_mode_bit_in) begin
				pa_val[i] = mcu_data_in[i]; // RQ14
				pa_en[i] = periph_on & mcu_data_write_in; // RQ15
			end else if (logic_output_in[i]) begin
				pa_val[i] = cfg_a_from_second_in[i] ? 1'b0
					: macrocell_group_first_in[i]; // RQ2 RQ11
			end else if (st_r.ctrl_a[i]) begin
				pa_val[i] = addr_low_in[i]; // RQ13
				pa_en[i] = (oe_term_defined_in[i] & oe_term_in[i]) |
					(st_r.dir_a[i] & st_r.ctrl_a[i]); // RQ13
			end else begin
				pa_val[i] = st_r.dout_a[i]; // RQ8 RQ9
			end
			// Port B
			pb_en[i] = pin_enable(st_r.dir_b[i], oe_term_in[W + i],
				oe_term_defined_in[W + i]);
			if (logic_output_in[W + i]) begin
				pb_val[i] = cfg_a_from_second_in[i] ? cells_b[i]
					: macrocell_group_first_in[i]; // RQ2 RQ18
			end else if (st_r.ctrl_b[i]) begin
				pb_val[i] = addr_low_in[i]; // RQ13
				pb_en[i] = (oe_term_defined_in[W + i] & oe_term_in[W + i]) |
					(st_r.dir_b[i] & st_r.ctrl_b[i]); // RQ13
			end else begin
				pb_val[i] = st_r.dout_b[i]; // RQ9
			end
			// Port C: no control register, cells on four pins only
			pc_en[i] = pin_enable(st_r.dir_c[i], oe_term_in[2*W + i],
				oe_term_defined_in[2*W + i]); // RQ10
			if (PORT_C_TEST_PINS[i]) begin
				pc_val[i] = 1'b0; // RQ17
				pc_en[i] = 1'b0; // RQ17
			end else if (logic_output_in[2*W + i] && PORT_C_CELL_PINS[i]) begin
				pc_val[i] = macrocell_group_second_in[i]; // RQ17 RQ11
			end else begin
				pc_val[i] = st_r.dout_c[i]; // RQ9 RQ10
			end
		end
		for (int j = 0; j < DW; j++) begin
			pd_en[j] = pin_enable(st_r.dir_d[j], oe_term_in[3*W + j],
				oe_term_defined_in[3*W + j]);
			// Only Port D carries the extra chip selects
			if (logic_output_in[3*W + j] && PORT_D_CS_PINS[j]) begin
				pd_val[j] = external_chip_selects_in[j == 2]; // RQ18 RQ2
			end else begin
				pd_val[j] = st_r.dout_d[j]; // RQ10
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes and readback
	always_comb begin
		st_nxt = st_r;
		if (wr_strobe_in) begin // RQ21
			case (wr_target_in)
				WR_DATA_OUT: case (wr_port_in)
					PORT_A: st_nxt.dout_a = wr_data_in;
					PORT_B: st_nxt.dout_b = wr_data_in;
					PORT_C: st_nxt.dout_c = wr_data_in;
					default: st_nxt.dout_d = wr_data_in[DW-1:0];
				endcase
				WR_DIR: case (wr_port_in)
					PORT_A: st_nxt.dir_a = wr_data_in;
					PORT_B: st_nxt.dir_b = wr_data_in;
					PORT_C: st_nxt.dir_c = wr_data_in;
					default: st_nxt.dir_d = wr_data_in[DW-1:0];
				endcase
				// Ports C and D hold no control bits
				WR_CTRL: case (wr_port_in)
					PORT_A: st_nxt.ctrl_a = wr_data_in; // RQ7
					PORT_B: st_nxt.ctrl_b = wr_data_in; // RQ7
					default: st_nxt.ctrl_a = st_r.ctrl_a; // RQ10
				endcase
				default: case (wr_port_in)
					PORT_A: st_nxt.drive_a = wr_data_in;
					PORT_B: st_nxt.drive_b = wr_data_in;
					PORT_C: st_nxt.drive_c = wr_data_in;
					default: st_nxt.drive_d = wr_data_in[DW-1:0];
				endcase
			endcase
		end
		// One source at a time onto the data bus, no side effects
		case (rd_source_in) // RQ3 RQ21
			RB_DATA_OUT: case (rd_port_in)
				PORT_A: st_nxt.rb = st_r.dout_a;
				PORT_B: st_nxt.rb = st_r.dout_b;
				PORT_C: st_nxt.rb = st_r.dout_c;
				default: st_nxt.rb = widen(st_r.dout_d);
			endcase
			RB_CELL_OUT: case (rd_port_in)
				PORT_A: st_nxt.rb = macrocell_group_first_in;
				PORT_B: st_nxt.rb = macrocell_group_second_in;
				default: st_nxt.rb = 8'h00;
			endcase
			RB_DIR: case (rd_port_in)
				PORT_A: st_nxt.rb = st_r.dir_a;
				PORT_B: st_nxt.rb = st_r.dir_b;
				PORT_C: st_nxt.rb = st_r.dir_c;
				default: st_nxt.rb = widen(st_r.dir_d);
			endcase
			RB_CTRL: case (rd_port_in)
				PORT_A: st_nxt.rb = st_r.ctrl_a;
				PORT_B: st_nxt.rb = st_r.ctrl_b;
				default: st_nxt.rb = 8'h00; // RQ10
			endcase
			RB_PIN: case (rd_port_in)
				PORT_A: st_nxt.rb = port_a_pin_in; // RQ9
				PORT_B: st_nxt.rb = port_b_pin_in;
				PORT_C: st_nxt.rb = port_c_pin_in;
				default: st_nxt.rb = widen(port_d_pin_in);
			endcase
			RB_CAPTURE: case (rd_port_in)
				PORT_A: st_nxt.rb = cap_a; // RQ6
				PORT_B: st_nxt.rb = cap_b;
				PORT_C: st_nxt.rb = cap_c & PORT_C_CELL_PINS;
				default: st_nxt.rb = 8'h00;
			endcase
			RB_ENABLE: case (rd_port_in)
				PORT_A: st_nxt.rb = st_r.pa_oe;
				PORT_B: st_nxt.rb = st_r.pb_oe;
				PORT_C: st_nxt.rb = st_r.pc_oe;
				default: st_nxt.rb = widen(st_r.pd_oe);
			endcase
			default: st_nxt.rb = 8'h00;
		endcase
		st_nxt.pa_q = pa_val;
		st_nxt.pa_oe = pa_en;
		st_nxt.pb_q = pb_val;
		st_nxt.pb_oe = pb_en;
		st_nxt.pc_q = pc_val;
		st_nxt.pc_oe = pc_en;
		st_nxt.pd_q = pd_val;
		st_nxt.pd_oe = pd_en;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_r <= '0; // RQ19 RQ20
		end else begin
			st_r <= st_nxt;
		end
	end

	assign port_a_pin_out = st_r.pa_q;
	assign port_a_oe_out = st_r.pa_oe;
	assign port_b_pin_out = st_r.pb_q;
	assign port_b_oe_out = st_r.pb_oe;
	assign port_c_pin_out = st_r.pc_q;
	assign port_c_oe_out = st_r.pc_oe;
	assign port_d_pin_out = st_r.pd_q;
	assign port_d_oe_out = st_r.pd_oe;
	assign port_readback_buffer_out = st_r.rb;
	assign open_drain_a_out = st_r.drive_a;
	assign open_drain_b_out = st_r.drive_b;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_dir_write_a;
		wr_strobe_in && wr_target_in == WR_DIR && wr_port_in == PORT_A;
	endsequence
	property p_reset_inputs;
		@(posedge clk_in) !rst_n_in |=> port_a_oe_out == '0 &&
			port_b_oe_out == '0 && port_d_oe_out == '0;
	endproperty
	a_reset_inputs: assert property (p_reset_inputs) // RQ19
		else $error("Pins not inputs after reset");

	property p_dir_stored;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_dir_write_a |=> st_r.dir_a == $past(wr_data_in);
	endproperty
	a_dir_stored: assert property (p_dir_stored) // RQ21
		else $error("Direction write lost");

	property p_cfg_reset;
		@(posedge clk_in) !rst_n_in |=> st_r.ctrl_a == CFG_RESET &&
			st_r.dir_c == CFG_RESET && st_r.drive_b == CFG_RESET;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) // RQ20
		else $error("Configuration not zero after reset");

	property p_or_enable;
		@(posedge clk_in) disable iff (!rst_n_in)
		!periph_mode_bit_in && st_r.ctrl_b[0] == 1'b0 |=>
			port_b_oe_out[0] == ($past(st_r.dir_b[0]) |
			($past(oe_term_defined_in[W]) & $past(oe_term_in[W])));
	endproperty
	a_or_enable: assert property (p_or_enable) // RQ4
		else $error("Port B pin 0 enable not OR of direction and term");

	property p_test_pins_off;
		@(posedge clk_in) disable iff (!rst_n_in)
		(port_c_oe_out & PORT_C_TEST_PINS) == '0;
	endproperty
	a_test_pins_off: assert property (p_test_pins_off) // RQ17
		else $error("Test pin on Port C driven");

	property p_periph_off;
		@(posedge clk_in) disable iff (!rst_n_in)
		periph_mode_bit_in && !periph_select_zero_in &&
			!periph_select_one_in |=> port_a_oe_out == '0;
	endproperty
	a_periph_off: assert property (p_periph_off) // RQ15
		else $error("Peripheral buffer on while select inactive");

	property p_data_out_drive;
		@(posedge clk_in) disable iff (!rst_n_in)
		!periph_mode_bit_in && !logic_output_in[0] && !st_r.ctrl_a[0] |=>
			port_a_pin_out[0] == $past(st_r.dout_a[0]);
	endproperty
	a_data_out_drive: assert property (p_data_out_drive) // RQ9
		else $error("Port A pin 0 not from data register");

	property p_addr_out;
		@(posedge clk_in) disable iff (!rst_n_in)
		!logic_output_in[W + 4] && st_r.ctrl_b[4] |=>
			port_b_pin_out[4] == $past(addr_low_in[4]);
	endproperty
	a_addr_out: assert property (p_addr_out) // RQ13
		else $error("Port B pin 4 not carrying address bit 4");

	property p_readback_ctrl;
		@(posedge clk_in) disable iff (!rst_n_in)
		rd_source_in == RB_CTRL && rd_port_in == PORT_C |=>
			port_readback_buffer_out == 8'h00;
	endproperty
	a_readback_ctrl: assert property (p_readback_ctrl) // RQ10
		else $error("Port C control readback not zero");
endmodule
`default_nettype wire

// >>> design/io_port_pkg.sv
// Constants shared by the configurable I/O port block
`default_nettype none
package io_port_pkg;
	localparam int unsigned PORT_W = 8;
	localparam int unsigned PORT_D_W = 3;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int unsigned PERIPH_MODE_POS = 7;
	// Port C pins that can carry macrocell outputs (PC2, PC3, PC4, PC7)
	localparam logic [7:0] PORT_C_CELL_PINS = 8'h9c;
	// Port C pins dedicated to the serial test interface
	localparam logic [7:0] PORT_C_TEST_PINS = 8'h63;
	// Port D pin used for an external chip select (two of them)
	localparam logic [2:0] PORT_D_CS_PINS = 3'h6;
	// Readback sources
	localparam logic [2:0] RB_DATA_OUT = 3'h0;
	localparam logic [2:0] RB_CELL_OUT = 3'h1;
	localparam logic [2:0] RB_DIR = 3'h2;
	localparam logic [2:0] RB_CTRL = 3'h3;
	localparam logic [2:0] RB_PIN = 3'h4;
	localparam logic [2:0] RB_CAPTURE = 3'h5;
	localparam logic [2:0] RB_ENABLE = 3'h6;
	// Register targets of a write
	localparam logic [1:0] WR_DATA_OUT = 2'h0;
	localparam logic [1:0] WR_DIR = 2'h1;
	localparam logic [1:0] WR_CTRL = 2'h2;
	localparam logic [1:0] WR_DRIVE = 2'h3;
	// Port numbers
	localparam logic [1:0] PORT_A = 2'h0;
	localparam logic [1:0] PORT_B = 2'h1;
	localparam logic [1:0] PORT_C = 2'h2;
	localparam logic [1:0] PORT_D = 2'h3;
	// Input cell modes
	typedef enum logic [1:0] {
		CELL_DIRECT,
		CELL_LATCH,
		CELL_REGISTER
	} cell_mode_e;
endpackage
`default_nettype wire

// >>> design/input_capture_cell.sv
// Input capture cell group for one eight-pin port
`default_nettype none
module input_capture_cell
	import io_port_pkg::*;
#(
	parameter int unsigned WIDTH = PORT_W
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] pin_in,
	input wire logic [WIDTH*2-1:0] cell_mode_in,
	input wire logic [WIDTH-1:0] use_term_in,
	input wire logic addr_strobe_in,
	input wire logic term_low_in,
	input wire logic term_high_in,
	output logic [WIDTH-1:0] cell_out
);
	typedef struct packed {
		logic [WIDTH-1:0] store;
		logic [WIDTH-1:0] strobe_prev;
	} cell_state_s;

	cell_state_s st_r;
	cell_state_s st_nxt;
	logic [WIDTH-1:0] strobe;

	always_comb begin
		st_nxt = st_r;
		for (int i = 0; i < WIDTH; i++) begin
			// Low nibble and high nibble each have their own term
			if (use_term_in[i]) begin
				strobe[i] = (i < WIDTH / 2) ? term_low_in : term_high_in;
			end else begin
				strobe[i] = addr_strobe_in;
			end
			st_nxt.strobe_prev[i] = strobe[i];
			case (cell_mode_e'(cell_mode_in[2*i +: 2]))
				CELL_LATCH: begin
					if (strobe[i]) begin
						st_nxt.store[i] = pin_in[i];
					end
				end
				CELL_REGISTER: begin
					if (strobe[i] && !st_r.strobe_prev[i]) begin
						st_nxt.store[i] = pin_in[i];
					end
				end
				default: begin
					st_nxt.store[i] = pin_in[i];
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cell_out = st_r.store;
endmodule
`default_nettype wire

// >>> verification/ext_pin_model.sv
// External devices and pull-ups seen on one port's pins
`default_nettype none
module ext_pin_model #(
	parameter int unsigned W = 8
) (
	input wire logic [W-1:0] drv_out_in,
	input wire logic [W-1:0] drv_oe_in,
	input wire logic [W-1:0] ext_val_in,
	input wire logic [W-1:0] ext_en_in,
	output logic [W-1:0] pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////////////////////////////////////
	// Device never fights the block; a pin nobody drives floats high
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (drv_oe_in[i])
				pin_out[i] = drv_out_in[i];
			else if (ext_en_in[i])
				pin_out[i] = ext_val_in[i];
			else
				pin_out[i] = 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the configurable I/O port block
`default_nettype none
module tb_top
	import io_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIMIT = 3000;
	logic clk = 1'b0, rst_n = 1'b0, wr_strobe = 1'b0;
	logic [1:0] wr_port = 2'h0, wr_target = 2'h0, rd_port = 2'h0;
	logic [7:0] wr_data = 8'h00, addr_low = 8'h00, mcu_data = 8'h00;
	logic [2:0] rd_source = 3'h0;
	logic addr_strobe = 1'b0, periph_mode = 1'b0, mcu_wr = 1'b0;
	logic periph_select_zero = 1'b0, periph_select_one = 1'b0;
	logic [7:0] mc_first = 8'h00, mc_second = 8'h00, cfg_second = 8'h00;
	logic [7:0] cfg_use_term = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
	logic [15:0] cfg_mode = 16'h0000;
	logic [26:0] oe_term = 27'h0, oe_def = 27'h0, lout = 27'h0;
	logic [1:0] ecs = 2'h0, term_a = 2'h0, term_b = 2'h0, term_c = 2'h0;
	logic [7:0] a_in, b_in, c_in, a_out, a_oe, b_out, b_oe, c_out, c_oe;
	logic [7:0] readback, od_a, od_b;
	logic [2:0] d_in, d_out, d_oe;
	int errors = 0, cmp_count = 0, cycles = 0;
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	configurable_io_port_block i_dut (.clk_in(clk), .rst_n_in(rst_n),
		.wr_strobe_in(wr_strobe), .wr_port_in(wr_port),
		.wr_target_in(wr_target), .wr_data_in(wr_data),
		.rd_port_in(rd_port), .rd_source_in(rd_source),
		.addr_low_in(addr_low), .addr_strobe_in(addr_strobe),
		.periph_mode_bit_in(periph_mode), .mcu_data_in(mcu_data),
		.mcu_data_write_in(mcu_wr), .periph_select_zero_in(periph_select_zero),
		.periph_select_one_in(periph_select_one), .macrocell_group_first_in(mc_first),
		.macrocell_group_second_in(mc_second),
		.external_chip_selects_in(ecs), .oe_term_in(oe_term),
		.oe_term_defined_in(oe_def), .logic_output_in(lout),
		.cell_term_a_in(term_a), .cell_term_b_in(term_b),
		.cell_term_c_in(term_c), .cfg_a_from_second_in(cfg_second),
		.cfg_cell_use_term_in(cfg_use_term), .cfg_cell_mode_in(cfg_mode),
		.port_a_pin_in(a_in), .port_b_pin_in(b_in), .port_c_pin_in(c_in),
		.port_d_pin_in(d_in), .port_a_pin_out(a_out), .port_a_oe_out(a_oe),
		.port_b_pin_out(b_out), .port_b_oe_out(b_oe),
		.port_c_pin_out(c_out), .port_c_oe_out(c_oe),
		.port_d_pin_out(d_out), .port_d_oe_out(d_oe),
		.port_readback_buffer_out(readback), .open_drain_a_out(od_a),
		.open_drain_b_out(od_b));
	ext_pin_model #(.W(8)) i_ext_a (.drv_out_in(a_out), .drv_oe_in(a_oe),
		.ext_val_in(ext_val), .ext_en_in(ext_en), .pin_out(a_in));
	ext_pin_model #(.W(8)) i_ext_b (.drv_out_in(b_out), .drv_oe_in(b_oe),
		.ext_val_in(ext_val), .ext_en_in(ext_en), .pin_out(b_in));
	ext_pin_model #(.W(8)) i_ext_c (.drv_out_in(c_out), .drv_oe_in(c_oe),
		.ext_val_in(ext_val), .ext_en_in(ext_en), .pin_out(c_in));
	ext_pin_model #(.W(3)) i_ext_d (.drv_out_in(d_out), .drv_oe_in(d_oe),
		.ext_val_in(ext_val[2:0]), .ext_en_in(ext_en[2:0]),
		.pin_out(d_in));
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [7:0] exp, input logic [7:0] got,
			input string what);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] port, input logic [1:0] tgt,
			input logic [7:0] d);
		@(posedge clk);
		#1;
		wr_strobe = 1'b1;
		wr_port = port;
		wr_target = tgt;
		wr_data = d;
		@(posedge clk);
		#1;
		wr_strobe = 1'b0;
	endtask
	// Registered outputs need two edges after any input change
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [1:0] port, input logic [2:0] src,
			input logic [7:0] exp, input string what);
		@(posedge clk);
		#1;
		rd_port = port;
		rd_source = src;
		settle();
		chk(exp, readback, what);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			errors++;
			$display("unexpected at %0t: run hung", $time);
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		settle();
		chk(8'h00, a_oe, "oe A after reset");
		chk(8'h00, b_oe, "oe B after reset");
		chk(8'h00, od_a, "drive A reset");
		rd(PORT_A, RB_DIR, 8'h00, "dir A reset");
		rd(PORT_B, RB_CTRL, 8'h00, "ctrl B reset");
		$display("test reset done");
		// Pins stay inputs here, so the device may drive them
		ext_en = 8'hff;
		ext_val = 8'h3c;
		rd(PORT_A, RB_PIN, 8'h3c, "pin A input");
		cfg_mode = 16'h5555;
		addr_strobe = 1'b1;
		settle();
		addr_strobe = 1'b0;
		settle();
		ext_val = 8'hc3;
		rd(PORT_A, RB_CAPTURE, 8'h3c, "latched A");
		rd(PORT_A, RB_PIN, 8'hc3, "pin A live");
		// Strobe held high: a register takes only its rising edge
		cfg_mode = 16'haaaa;
		cfg_use_term = 8'h0f;
		ext_val = 8'h5a;
		term_a = 2'h1;
		settle();
		ext_val = 8'h96;
		settle();
		term_a = 2'h0;
		rd(PORT_A, RB_CAPTURE, 8'h3a, "registered low A");
		$display("test input done");
		ext_en = 8'h00;
		wr(PORT_A, WR_DIR, 8'hff);
		wr(PORT_A, WR_DATA_OUT, 8'ha5);
		settle();
		chk(8'hff, a_oe, "oe A dir");
		chk(8'ha5, a_out, "pin A data");
		rd(PORT_A, RB_DATA_OUT, 8'ha5, "data A back");
		rd(PORT_A, RB_DIR, 8'hff, "dir A back");
		rd(PORT_A, RB_PIN, 8'ha5, "pin A driven");
		wr(PORT_A, WR_DRIVE, 8'hf0);
		wr(PORT_B, WR_DRIVE, 8'h0f);
		settle();
		chk(8'hf0, od_a, "drive A");
		chk(8'h0f, od_b, "drive B");
		$display("test output done");
		oe_term[15:8] = 8'h0f;
		oe_def[15:8] = 8'hff;
		mc_first = 8'h96;
		settle();
		chk(8'h0f, b_oe, "oe B term");
		rd(PORT_B, RB_ENABLE, 8'h0f, "enable B back");
		rd(PORT_A, RB_CELL_OUT, 8'h96, "cell A back");
		oe_def[15:8] = 8'h00;
		settle();
		chk(8'h00, b_oe, "oe B no term");
		$display("test enable done");
		addr_low = 8'h7e;
		wr(PORT_A, WR_CTRL, 8'hff);
		settle();
		chk(8'h7e, a_out, "address out A");
		rd(PORT_A, RB_CTRL, 8'hff, "ctrl A back");
		wr(PORT_A, WR_CTRL, 8'h00);
		settle();
		chk(8'ha5, a_out, "back to data A");
		wr(PORT_B, WR_DIR, 8'hff);
		wr(PORT_B, WR_CTRL, 8'hf0);
		settle();
		chk(8'h70, b_out, "address high B");
		lout[7:0] = 8'hff;
		settle();
		chk(8'h96, a_out, "cell out A");
		wr(PORT_A, WR_DIR, 8'h00);
		settle();
		chk(8'h00, a_oe, "cell out A off");
		lout[7:0] = 8'h00;
		$display("test address done");
		wr(PORT_C, WR_CTRL, 8'hff);
		rd(PORT_C, RB_CTRL, 8'h00, "ctrl C absent");
		wr(PORT_C, WR_DIR, 8'hff);
		wr(PORT_D, WR_DIR, 8'hff);
		settle();
		chk(~PORT_C_TEST_PINS, c_oe, "oe C test pins");
		chk(8'h07, {5'h00, d_oe}, "oe D width");
		mc_second = 8'hff;
		ecs = 2'h2;
		lout[26:16] = 11'h6ff;
		settle();
		chk(8'h9c, c_out, "cells on C");
		chk(8'h04, {5'h00, d_out}, "chip selects D");
		$display("test ports c d done");
		// Select stands for decode already qualified by program strobe
		periph_mode = 1'b1;
		mcu_wr = 1'b1;
		mcu_data = 8'h5a;
		settle();
		chk(8'h00, a_oe, "periph unselected");
		periph_select_zero = 1'b1;
		periph_select_one = 1'b1;
		settle();
		chk(8'hff, a_oe, "periph selected");
		chk(8'h5a, a_out, "periph data");
		$display("test peripheral done");
		report_and_stop();
	end
endmodule
`default_nettype wire
